// file: bench/stm_pin_src.sv
// Behavioural source for the external trigger and capture pins
`timescale 1ns/100ps

module stm_pin_src (
    input wire logic aclk,
    input wire logic trig_lvl,
    input wire logic cap_lvl,
    output logic ext_trigger_pin,
    output logic capture_pin
);
    // ==================================================================
    // Pin drive; pins move 3 ns after each aclk rising edge, off the sampling edge, to exercise the synchroniser
    always @(posedge aclk) begin
        #3;
        ext_trigger_pin <= trig_lvl;
        capture_pin <= cap_lvl;
    end
endmodule

// file: bench/timer_single_pulse_capture_tb.sv
// Self-checking testbench of the timer: single-pulse and capture modes
`timescale 1ns/100ps

`include "stm_defines.svh"

module timer_single_pulse_capture_tb
    import stm_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, trig, cap, pulse_out, fa, fp, ptrig, pcap;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, c, a, ex;
    logic [1:0] bresp, rresp, wresp, rr;
    logic [3:0] wstrb;
    int fail_count, n_compared, cyc, w, i, seed;

    // ==================================================================
    // Design and pin sources
    stm_timer u_stm_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_trigger_pin(ptrig), .capture_pin(pcap),
        .pulse_out(pulse_out), .match_a_flag(fa), .match_p_flag(fp));
    stm_pin_src u_stm_pin_src (.aclk(aclk), .trig_lvl(trig), .cap_lvl(cap),
        .ext_trigger_pin(ptrig), .capture_pin(pcap));

    // ==================================================================
    // Clock and hang guard
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // Long enough for every scenario, short enough to cut a hang
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            end_sim();
        end
    end

    // ==================================================================
    // Helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        n_compared++;
        if (seen !== expv) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] ad, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        wresp = bresp;
    endtask

    task automatic axr(input logic [7:0] ad);
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        rd = rdata;
        rr = rresp;
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    function automatic logic [31:0] cw(input logic [1:0] m, input logic [1:0] io,
        input logic pol, input logic run);
        cw = 32'h00000000;
        cw[`STM_MODE_LO +: 2] = m;
        cw[`STM_IO_LO +: 2] = io;
        cw[`STM_POL_BIT] = pol;
        cw[`STM_RUN_BIT] = run;
    endfunction

    // Counts active cycles of the pulse; bounded so a stuck output ends it
    task automatic pulse_width(input logic pol, output int wd);
        int k;
        k = 0;
        wd = 0;
        while (pulse_out !== ~pol && k < 40) begin
            @(posedge aclk);
            k++;
        end
        while (pulse_out === ~pol && wd < 2000) begin
            @(posedge aclk);
            wd++;
        end
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        seed = 32'h7FB9;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, trig, cap} = 8'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values and unmapped space
        for (i = 0; i <= 16; i += 4) begin
            axr(i[7:0]);
            chk(rd, 32'h00000000);
        end
        axr(8'h14);
        chk(rd, 32'h00000000);
        chk({30'h00000000, rr}, 32'h00000002);
        axw(8'h14, 32'h00000001);
        chk(wresp, 2'h2);
        // Software-started pulses, both polarities, unused P and clear bits set
        for (i = 0; i < 2; i++) begin
            a = 32'd2 + ($unsigned($random(seed)) % 14);
            ex = (32'h1 << `STM_DPX_BIT) | (32'h1 << `STM_CCLR_BIT);
            axw(`STM_CMPA_OFF, a);
            axw(`STM_CMPP_OFF, $random(seed) & 32'h000003FF);
            axw(`STM_FLAG_OFF, 32'h00000003);
            axw(`STM_CTRL_OFF, cw(`STM_MODE_SPULSE, `STM_IO_SPULSE, i[0], 1'b0) | ex);
            axw(`STM_CTRL_OFF, cw(`STM_MODE_SPULSE, `STM_IO_SPULSE, i[0], 1'b1) | ex);
            pulse_width(i[0], w);
            chk(w >= a + 1 && w <= a + 3, 32'h1);
            axr(`STM_CTRL_OFF);
            chk(rd[0], 32'h0);
            axr(`STM_FLAG_OFF);
            chk(rd[1:0], 32'h1);
            chk(fp, 32'h0);
            axr(`STM_CNT_OFF);
            c = rd;
            waitc(10);
            axr(`STM_CNT_OFF);
            chk(rd, c);
        end
        // Pulse started from the trigger pin
        axw(`STM_CMPA_OFF, 32'd60);
        axw(`STM_FLAG_OFF, 32'h00000003);
        axw(`STM_CTRL_OFF, cw(`STM_MODE_SPULSE, `STM_IO_SPULSE, 1'b0, 1'b0));
        trig <= 1'b1;
        waitc(8);
        chk(pulse_out, 32'h1);
        axr(`STM_CTRL_OFF);
        chk(rd[0], 32'h1);
        waitc(80);
        chk(pulse_out, 32'h0);
        axr(`STM_FLAG_OFF);
        chk(rd[0], 32'h1);
        chk(fa, 32'h1);
        // Falling-edge trigger select starts the next pulse
        ex = 32'h1 << `STM_TRIG_EDGE_BIT;
        axw(`STM_CTRL_OFF, cw(`STM_MODE_SPULSE, `STM_IO_SPULSE, 1'b0, 1'b0) | ex);
        trig <= 1'b0;
        waitc(8);
        chk(pulse_out, 32'h1);
        waitc(80);
        chk(pulse_out, 32'h0);
        // Zero A value: only a software clear ends the pulse
        axw(`STM_CMPA_OFF, 32'h00000000);
        axw(`STM_CTRL_OFF, cw(`STM_MODE_SPULSE, `STM_IO_SPULSE, 1'b0, 1'b1));
        waitc(50);
        chk(pulse_out, 32'h1);
        axw(`STM_CTRL_OFF, cw(`STM_MODE_SPULSE, `STM_IO_SPULSE, 1'b0, 1'b0));
        waitc(3);
        chk(pulse_out, 32'h0);
        // Capture with P of zero: full range, one capture mid-run
        axw(`STM_CMPP_OFF, 32'h00000000);
        axw(`STM_CTRL_OFF, cw(`STM_MODE_CAPT, `STM_IO_CAP_RISE, 1'b1, 1'b0));
        axw(`STM_FLAG_OFF, 32'h00000003);
        axw(`STM_CTRL_OFF, cw(`STM_MODE_CAPT, `STM_IO_CAP_RISE, 1'b1, 1'b1));
        waitc(300);
        cap <= 1'b1;
        waitc(8);
        chk(pulse_out, 32'h0);
        axr(`STM_CMPA_OFF);
        chk(rd > 250 && rd < 400, 32'h1);
        waitc(400);
        axr(`STM_CNT_OFF);
        chk(rd > 32'h200 && rd <= 32'h3FF, 32'h1);
        axr(`STM_FLAG_OFF);
        chk(rd[1:0], 32'h1);
        waitc(350);
        axr(`STM_FLAG_OFF);
        chk(rd[1], 32'h1);
        chk(fp, 32'h1);
        // Every edge selection, falling then rising
        for (i = 0; i < 4; i++) begin
            axw(`STM_CTRL_OFF, cw(`STM_MODE_CAPT, i[1:0], 1'b1, 1'b1));
            axw(`STM_FLAG_OFF, 32'h00000003);
            cap <= ~cap;
            waitc(8);
            axr(`STM_FLAG_OFF);
            chk(rd[0], cap ? (i == 0 || i == 2) : (i == 1 || i == 2));
            axw(`STM_FLAG_OFF, 32'h00000003);
            cap <= ~cap;
            waitc(8);
            axr(`STM_FLAG_OFF);
            chk(rd[0], cap ? (i == 0 || i == 2) : (i == 1 || i == 2));
        end
        // Small P value bounds the count
        a = 32'd20 + ($unsigned($random(seed)) % 30);
        axw(`STM_CMPP_OFF, a);
        axw(`STM_CTRL_OFF, cw(`STM_MODE_CAPT, `STM_IO_CAP_OFF, 1'b0, 1'b0));
        axw(`STM_FLAG_OFF, 32'h00000003);
        axw(`STM_CTRL_OFF, cw(`STM_MODE_CAPT, `STM_IO_CAP_OFF, 1'b0, 1'b1));
        repeat (8) begin
            axr(`STM_CNT_OFF);
            chk(rd <= a, 32'h1);
            waitc(8);
        end
        axr(`STM_FLAG_OFF);
        chk(rd[1], 32'h1);
        // Stopping freezes the counter
        axw(`STM_CTRL_OFF, cw(`STM_MODE_CAPT, `STM_IO_CAP_OFF, 1'b0, 1'b0));
        axr(`STM_CNT_OFF);
        c = rd;
        waitc(20);
        axr(`STM_CNT_OFF);
        chk(rd, c);
        end_sim();
    end
endmodule

// file: hw/stm_pin_sync.sv
// Two-flop synchroniser and edge detector for one external pin
`timescale 1ns/100ps

`include "stm_defines.svh"

module stm_pin_sync
    import stm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    output stm_edge_t edge_o
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // ==================================================================
    // Synchroniser: only sync_r looks at meta_r
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Edges seen after the synchroniser
    assign edge_o.rise = sync_r & ~prev_r;
    assign edge_o.fall = ~sync_r & prev_r;

endmodule

// file: hw/stm_timer.sv
// 10-bit timer: single-pulse output and capture input, AXI4-Lite registers
// ======================================================================
// Summary of operation
// - Single pulse: run-enable rising starts pulse leading edge.
// - Single pulse: trigger pin active edge sets run-enable.
// - Counter starts together with the pulse leading edge.
// - Clearing run-enable, by software or match A, ends the pulse.
// - Single pulse: match A clears run-enable, A sets pulse width.
// - Single pulse: match A raises the A flag.
// - Single pulse: counter zeroes only on run-enable rising.
// - Single pulse: P value, clear-select and swap bits ignored.
// - Capture edge rising, falling or both by output-control; 11 disables.
// - Capture: counter starts when software raises run-enable.
// - Capture edge copies counter into A and raises A flag.
// - Capture: counter runs until run-enable falls.
// - Capture: match P zeroes the counter.
// - Capture: match P raises the P flag.
// - P value zero lets the counter run its full range.
// - Capture drives no output; initial-state, polarity, clear-select ignored.
// - Counter is 10 bits, overflowing after 3FF.
// - Separate A and P flags are kept.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps

`include "stm_defines.svh"

module stm_timer
    import stm_pkg::*;
#(
    parameter int CNT_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_trigger_pin,
    input wire logic capture_pin,
    output logic pulse_out,
    output logic match_a_flag,
    output logic match_p_flag
);

    // ==================================================================
    // Declarations
    stm_ctrl_t ctrl_r;
    logic [CNT_W-1:0] cmpa_r;
    logic [CNT_W-1:0] cmpp_r;
    logic [CNT_W-1:0] cnt_r;
    logic run_prev_r;
    logic [7:0] awaddr_r;
    logic aw_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_held_r;
    stm_state_t state_r;
    stm_edge_t trig_e;
    stm_edge_t cap_e;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_cmpa;
    logic wr_flag;
    logic [31:0] wr_data;
    logic mode_sp;
    logic mode_cap;
    logic run_rise;
    logic run_fall;
    logic match_a;
    logic match_p;
    logic trig_act;
    logic cap_act;
    logic [CNT_W-1:0] cnt_top;

    // ==================================================================
    // Pin synchronisers
    stm_pin_sync u_trig_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(ext_trigger_pin),
        .edge_o(trig_e)
    );

    stm_pin_sync u_cap_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(capture_pin),
        .edge_o(cap_e)
    );

    // ==================================================================
    // Decode of mode and events
    assign mode_sp = (ctrl_r.mode_select == `STM_MODE_SPULSE);
    assign mode_cap = (ctrl_r.mode_select == `STM_MODE_CAPT);
    assign run_rise = ctrl_r.run_enable & ~run_prev_r;
    assign run_fall = ~ctrl_r.run_enable & run_prev_r;
    // Zero P leaves the full 10-bit range
    assign cnt_top = (cmpp_r == '0) ? CNT_W'(`STM_CNT_MAX) : cmpp_r;
    // Match only counts while running; A of zero never matches a live pulse
    assign match_a = (state_r == STM_PULSE) && (cnt_r == cmpa_r) && (cmpa_r != '0);
    assign match_p = (state_r == STM_CAPTURE) && (cnt_r == cnt_top);
    // Trigger polarity is selectable; rising by default
    assign trig_act = ctrl_r.trig_falling ? trig_e.fall : trig_e.rise;

    // Capture edge select by output-control
    always_comb begin
        case (ctrl_r.output_ctrl)
            `STM_IO_CAP_RISE: cap_act = cap_e.rise;
            `STM_IO_CAP_FALL: cap_act = cap_e.fall;
            `STM_IO_CAP_BOTH: cap_act = cap_e.rise | cap_e.fall;
            default: cap_act = 1'b0;
        endcase
    end

    // ==================================================================
    // AXI4-Lite write channel: address and data taken in either order
    assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
    assign wr_data = wdata_r;
    assign wr_ctrl = wr_fire && (awaddr_r == `STM_CTRL_OFF) && wstrb_r[0];
    assign wr_cmpa = wr_fire && (awaddr_r == `STM_CMPA_OFF) && wstrb_r[0];
    assign wr_flag = wr_fire && (awaddr_r == `STM_FLAG_OFF) && wstrb_r[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
                aw_held_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_held_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                // Unmapped offsets answer SLVERR
                s_axi_bresp <= (awaddr_r > `STM_FLAG_OFF) ? 2'h2 : 2'h0;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==================================================================
    // AXI4-Lite read channel: one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case ({s_axi_araddr[7:2], 2'h0})
                `STM_CTRL_OFF: s_axi_rdata <= {22'h000000, ctrl_r};
                `STM_CMPA_OFF: s_axi_rdata <= {22'h000000, cmpa_r};
                `STM_CMPP_OFF: s_axi_rdata <= {22'h000000, cmpp_r};
                `STM_CNT_OFF: s_axi_rdata <= {22'h000000, cnt_r};
                `STM_FLAG_OFF: s_axi_rdata <= {30'h00000000, match_p_flag, match_a_flag};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==================================================================
    // Control register; hardware set and clear of run-enable win over writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= stm_ctrl_t'(`STM_CTRL_RST);
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= stm_ctrl_t'(wr_data[9:0]);
            end
            if (mode_sp && trig_act) begin
                ctrl_r.run_enable <= 1'b1;
            end else if (match_a) begin
                ctrl_r.run_enable <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_prev_r <= 1'b0;
        end else begin
            run_prev_r <= ctrl_r.run_enable;
        end
    end

    // ==================================================================
    // Compare registers; capture beats a software write to A
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmpa_r <= CNT_W'(`STM_CMP_RST);
            cmpp_r <= CNT_W'(`STM_CMP_RST);
        end else begin
            if (state_r == STM_CAPTURE && cap_act) begin
                cmpa_r <= cnt_r;
            end else if (wr_cmpa) begin
                cmpa_r <= wr_data[CNT_W-1:0];
            end
            if (wr_fire && awaddr_r == `STM_CMPP_OFF && wstrb_r[0]) begin
                cmpp_r <= wr_data[CNT_W-1:0];
            end
        end
    end

    // ==================================================================
    // Counter state: started on run-enable rising, stopped on its fall
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= STM_IDLE;
        end else begin
            case (state_r)
                STM_IDLE: begin
                    if (run_rise && mode_sp) begin
                        state_r <= STM_PULSE;
                    end else if (run_rise && mode_cap) begin
                        state_r <= STM_CAPTURE;
                    end else if (run_rise) begin
                        state_r <= STM_OTHER;
                    end
                end
                STM_PULSE, STM_CAPTURE, STM_OTHER: begin
                    if (!ctrl_r.run_enable) begin
                        state_r <= STM_IDLE;
                    end
                end
                default: state_r <= STM_IDLE;
            endcase
        end
    end

    // Counter; single pulse ignores P, clear-select and swap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
        end else if (run_rise) begin
            cnt_r <= '0;
        end else if (state_r == STM_CAPTURE && match_p) begin
            cnt_r <= '0;
        end else if (state_r == STM_PULSE && !match_a) begin
            cnt_r <= cnt_r + 1'b1;
        end else if (state_r == STM_CAPTURE) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // ==================================================================
    // Sticky flags; a hardware set wins over a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
        end else begin
            if (match_a || (state_r == STM_CAPTURE && cap_act)) begin
                match_a_flag <= 1'b1;
            end else if (wr_flag && wr_data[`STM_FLAG_A_BIT]) begin
                match_a_flag <= 1'b0;
            end
            if (match_p) begin
                match_p_flag <= 1'b1;
            end else if (wr_flag && wr_data[`STM_FLAG_P_BIT]) begin
                match_p_flag <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Pulse output: active while running in single pulse, held low in other modes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_out <= 1'b0;
        end else if (mode_sp) begin
            pulse_out <= ctrl_r.run_enable ^ ctrl_r.output_polarity;
        end else begin
            pulse_out <= 1'b0;
        end
    end

    // ==================================================================
    // Assertions
    a_pulse_start: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode_sp && run_rise && !ctrl_r.output_polarity) |=> pulse_out)
        else $error("pulse did not start on run rising");
    a_trig_sets_run: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode_sp && trig_act) |=> ctrl_r.run_enable)
        else $error("trigger did not set run enable");
    a_match_a_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        (match_a && !(mode_sp && trig_act)) |=> !ctrl_r.run_enable ##1 state_r == STM_IDLE)
        else $error("match A did not stop the pulse");
    a_match_a_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        match_a |=> match_a_flag)
        else $error("match A flag not raised");
    a_capture_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_r == STM_CAPTURE && cap_act) |=> (cmpa_r == $past(cnt_r)) && match_a_flag)
        else $error("capture did not copy the counter");
    a_p_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        (match_p && !run_rise) |=> (cnt_r == '0) && match_p_flag)
        else $error("match P did not wrap the counter");
    a_cap_runs: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_r == STM_CAPTURE && !match_p && !run_rise && ctrl_r.run_enable)
        |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("capture counter stalled");
    a_cap_no_out: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_cap [*2] |-> !pulse_out)
        else $error("output driven in capture mode");

    c_pulse: cover property (@(posedge aclk) disable iff (!aresetn) match_a);
    c_capture: cover property (@(posedge aclk) disable iff (!aresetn)
        state_r == STM_CAPTURE && cap_act);
    c_wrap: cover property (@(posedge aclk) disable iff (!aresetn) match_p);

endmodule

// file: pkg/stm_defines.svh
// Register offsets, field positions, reset values and counts of the timer block
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH

// ======================================================================
// Register byte offsets (AXI4-Lite, one aligned word each)
`define STM_CTRL_OFF 8'h00
`define STM_CMPA_OFF 8'h04
`define STM_CMPP_OFF 8'h08
`define STM_CNT_OFF 8'h0C
`define STM_FLAG_OFF 8'h10

// ======================================================================
// Control register field positions
`define STM_RUN_BIT 0
`define STM_OC_BIT 1
`define STM_POL_BIT 2
`define STM_DPX_BIT 3
`define STM_CCLR_BIT 4
`define STM_IO_LO 5
`define STM_MODE_LO 7
`define STM_TRIG_EDGE_BIT 9

// Flag register field positions
`define STM_FLAG_A_BIT 0
`define STM_FLAG_P_BIT 1

// ======================================================================
// Reset values and counter limits
`define STM_CTRL_RST 10'h000
`define STM_CMP_RST 10'h000
`define STM_CNT_MAX 10'h3FF

// Mode and output-control encodings
`define STM_MODE_SPULSE 2'h2
`define STM_MODE_CAPT 2'h1
`define STM_IO_SPULSE 2'h3
`define STM_IO_CAP_RISE 2'h0
`define STM_IO_CAP_FALL 2'h1
`define STM_IO_CAP_BOTH 2'h2
`define STM_IO_CAP_OFF 2'h3

`endif

// file: pkg/stm_pkg.sv
// Types shared by the timer block
package stm_pkg;

    // Operating state of the counter
    typedef enum logic [1:0] {
        STM_IDLE,
        STM_PULSE,
        STM_CAPTURE,
        STM_OTHER
    } stm_state_t;

    // Control word as software sees it
    typedef struct packed {
        logic trig_falling;
        logic [1:0] mode_select;
        logic [1:0] output_ctrl;
        logic counter_clear_select;
        logic duty_period_swap;
        logic output_polarity;
        logic output_initial_state;
        logic run_enable;
    } stm_ctrl_t;

    // Edge pulses of a synchronised pin
    typedef struct packed {
        logic rise;
        logic fall;
    } stm_edge_t;

endpackage
